// [src/ssrm_defs.vh]
// constants for the separate-port synchronous sram model
// assumes inclusion by the device files only
`ifndef SSRM_DEFS_VH
`define SSRM_DEFS_VH
// -----------------------------------------------
// widths of the 18-bit variant
// -----------------------------------------------
`define SSRM_DATA_W 18
`define SSRM_ADDR_W 19
`define SSRM_LANE_W 9
`define SSRM_LANES 2
// -----------------------------------------------
// read pipeline states
// -----------------------------------------------
`define SSRM_RD_IDLE 2'h0
`define SSRM_RD_W0 2'h1
`define SSRM_RD_W1 2'h2
`define SSRM_RD_HOLD 2'h3
`endif

// [src/ssrm_edge_sync.v]
// two-flop synchroniser with rising-edge pulse for one pin-level clock
// assumes the input is asynchronous to clock
`timescale 1ns/1ns
`default_nettype none
module ssrm_edge_sync (
  input wire clock,
  input wire srst,
  input wire pin_in,
  output wire level_out,
  output wire rise_out
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;
  // -----------------------------------------------
  // sync and edge find
  // -----------------------------------------------
  // meta_reg feeds sync_reg, and prev_reg too while in reset
  always @(posedge clock) begin
    if (srst) begin
      // keep following the pin in reset so an idle-high pin gives no false edge
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= meta_reg;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  assign level_out = sync_reg;
  assign rise_out = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

// [src/ssrm_core.v]
// pin-level model of a synchronous sram with separate read and write ports
// assumes all pins, link clocks included, are asynchronous to clock
// and that pin clocks are far slower than clock
// and that the controller holds pins steady around each pin clock edge
`timescale 1ns/1ns
`default_nettype none
`include "ssrm_defs.vh"
// Operation
// - lane strobes active low, sampled on true and complementary input clock
// - strobe n governs write-word lane n of nine bits
// - deasserted strobe leaves that lane unchanged for that beat
// - strobes and data of a beat are sampled on the same edge
// - shared address: read on true edge, write on complementary edge
// - two banks chosen by burst position; the top address bit is not used
// - address ignored when the matching port select is deasserted
// - read select active low on true edge starts a read there
// - on deselect finish pending read, float outputs after next true launch edge
// - every read returns two consecutive words
// - normal mode launches words on rising output clock pair edges
// - single-clock mode launches words on input clock pair edges
// - every access starts on the true input clock rising edge
// - echo clocks run freely, synchronised to the output clock pair
// - single-clock mode derives echo clocks from input clock pair
// - write select active low on true edge starts write, else data ignored
// - write data sampled on both input clock rising edges
module ssrm_core #(
  parameter DATA_W = `SSRM_DATA_W,
  parameter ADDR_W = `SSRM_ADDR_W,
  parameter LANE_W = `SSRM_LANE_W,
  parameter LANES = `SSRM_LANES
) (
  input wire clock,
  input wire srst,
  input wire in_clk_p,
  input wire in_clk_n,
  input wire out_clk_p,
  input wire out_clk_n,
  input wire single_clock_mode,
  input wire read_port_select_n,
  input wire write_port_select_n,
  input wire [LANES-1:0] lane_write_strobe_n,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] wdata,
  output reg [DATA_W-1:0] rdata,
  output reg rdata_oe_n,
  output reg echo_strobe,
  output reg echo_strobe_n
);
  localparam WORD_A = ADDR_W - 1;
  localparam DEPTH = 1 << WORD_A;
  // bit positions inside the synchronised pin word
  localparam PIN_W = ADDR_W + DATA_W + LANES + 3;
  localparam POS_ADDR = DATA_W;
  localparam POS_STROBE = ADDR_W + DATA_W;
  localparam POS_WPS = ADDR_W + DATA_W + LANES;
  localparam POS_RPS = POS_WPS + 1;
  localparam POS_MODE = POS_WPS + 2;
  // -----------------------------------------------
  // helper functions
  // -----------------------------------------------
  // keep stored bits where the lane is masked off
  function [DATA_W-1:0] lane_merge;
    input [DATA_W-1:0] old_word;
    input [DATA_W-1:0] new_word;
    input [DATA_W-1:0] mask;
    begin
      lane_merge = (old_word & ~mask) | (new_word & mask);
    end
  endfunction
  // true where a queued read may start on the next launch edge
  function burst_open;
    input [1:0] state;
    begin
      case (state)
        `SSRM_RD_IDLE: burst_open = 1'b1;
        `SSRM_RD_W1: burst_open = 1'b1;
        `SSRM_RD_HOLD: burst_open = 1'b1;
        default: burst_open = 1'b0;
      endcase
    end
  endfunction
  // -----------------------------------------------
  // pin synchronisers
  // -----------------------------------------------
  wire kp_lvl;
  wire kp_rise;
  wire kn_lvl;
  wire kn_rise;
  wire cp_lvl;
  wire cp_rise;
  wire cn_lvl;
  wire cn_rise;
  ssrm_edge_sync u_kp (.clock(clock), .srst(srst), .pin_in(in_clk_p),
    .level_out(kp_lvl), .rise_out(kp_rise));
  ssrm_edge_sync u_kn (.clock(clock), .srst(srst), .pin_in(in_clk_n),
    .level_out(kn_lvl), .rise_out(kn_rise));
  ssrm_edge_sync u_cp (.clock(clock), .srst(srst), .pin_in(out_clk_p),
    .level_out(cp_lvl), .rise_out(cp_rise));
  ssrm_edge_sync u_cn (.clock(clock), .srst(srst), .pin_in(out_clk_n),
    .level_out(cn_lvl), .rise_out(cn_rise));
  // data pins pass two flops too, matching the clock pin delay
  // one stage less would leave a metastable window on every pin
  reg [PIN_W-1:0] pin_meta_reg;
  reg [PIN_W-1:0] pin_sync_reg;
  always @(posedge clock) begin
    if (srst) begin
      pin_meta_reg <= {PIN_W{1'b1}};
      pin_sync_reg <= {PIN_W{1'b1}};
    end else begin
      pin_meta_reg <= {single_clock_mode, read_port_select_n, write_port_select_n,
        lane_write_strobe_n, addr, wdata};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  wire [DATA_W-1:0] s_wdata = pin_sync_reg[DATA_W-1:0];
  wire [ADDR_W-1:0] s_addr = pin_sync_reg[POS_ADDR +: ADDR_W];
  wire [LANES-1:0] s_strobe_n = pin_sync_reg[POS_STROBE +: LANES];
  wire s_wps_n = pin_sync_reg[POS_WPS];
  wire s_rps_n = pin_sync_reg[POS_RPS];
  wire s_single = pin_sync_reg[POS_MODE];
  // -----------------------------------------------
  // array, two banks by burst position
  // -----------------------------------------------
  reg [DATA_W-1:0] bank0 [0:DEPTH-1];
  reg [DATA_W-1:0] bank1 [0:DEPTH-1];
  // -----------------------------------------------
  // write port
  // -----------------------------------------------
  reg wr_pend_reg;
  reg wr_armed_reg;
  reg wr_beat_reg;
  reg [WORD_A-1:0] wr_addr_reg;
  reg [DATA_W-1:0] wr_data_reg;
  reg [LANES-1:0] wr_strobe_n_reg;
  wire [DATA_W-1:0] wr_mask;
  wire wr_do;
  // lane masks, one per strobe; a high strobe keeps the stored lane
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl = gl + 1) begin : g_lane
      assign wr_mask[gl*LANE_W +: LANE_W] =
        {LANE_W{~wr_strobe_n_reg[gl]}};
    end
  endgenerate
  // beat 0 on true edge, beat 1 on following complementary edge
  always @(posedge clock) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      wr_armed_reg <= 1'b0;
      wr_beat_reg <= 1'b0;
      wr_addr_reg <= {WORD_A{1'b0}};
      wr_data_reg <= {DATA_W{1'b0}};
      wr_strobe_n_reg <= {LANES{1'b1}};
    end else begin
      wr_pend_reg <= 1'b0;
      if (kp_rise && !s_wps_n) begin
        wr_armed_reg <= 1'b1;
        wr_data_reg <= s_wdata;
        wr_strobe_n_reg <= s_strobe_n;
        wr_beat_reg <= 1'b0;
        wr_pend_reg <= 1'b1;
      end else if (kn_rise && wr_armed_reg) begin
        wr_armed_reg <= 1'b0;
        wr_addr_reg <= s_addr[WORD_A-1:0];
        wr_data_reg <= s_wdata;
        wr_strobe_n_reg <= s_strobe_n;
        wr_beat_reg <= 1'b1;
        wr_pend_reg <= 1'b1;
      end
    end
  end
  // first beat held until its address arrives on the complementary edge
  reg [DATA_W-1:0] wr_first_reg;
  reg [DATA_W-1:0] wr_first_mask_reg;
  assign wr_do = wr_pend_reg && wr_beat_reg;
  always @(posedge clock) begin
    if (srst) begin
      wr_first_reg <= {DATA_W{1'b0}};
      wr_first_mask_reg <= {DATA_W{1'b0}};
    end else if (wr_pend_reg && !wr_beat_reg) begin
      wr_first_reg <= wr_data_reg;
      wr_first_mask_reg <= wr_mask;
    end
  end
  // -----------------------------------------------
  // write commit
  // -----------------------------------------------
  always @(posedge clock) begin
    if (wr_do) begin
      bank0[wr_addr_reg] <= lane_merge(bank0[wr_addr_reg], wr_first_reg,
        wr_first_mask_reg);
      bank1[wr_addr_reg] <= lane_merge(bank1[wr_addr_reg], wr_data_reg,
        wr_mask);
    end
  end
  // -----------------------------------------------
  // read port
  // -----------------------------------------------
  reg [1:0] rd_state_reg;
  reg [1:0] rd_state_next;
  reg [WORD_A-1:0] rd_addr_reg;
  reg rd_queued_reg;
  reg [WORD_A-1:0] rd_qaddr_reg;
  // -----------------------------------------------
  // launch source
  // -----------------------------------------------
  // mode is taken up in every idle cycle, the launch cycle included, so a burst mixes pairs only if mode changes there
  reg single_reg;
  always @(posedge clock) begin
    if (srst) begin
      single_reg <= 1'b0;
    end else if (rd_state_reg == `SSRM_RD_IDLE) begin
      single_reg <= s_single;
    end
  end
  wire launch_p = single_reg ? kp_rise : cp_rise;
  wire launch_n = single_reg ? kn_rise : cn_rise;
  // -----------------------------------------------
  // read queue
  // -----------------------------------------------
  // a read taken mid-burst waits for the burst to end: no word is dropped
  always @(posedge clock) begin
    if (srst) begin
      rd_queued_reg <= 1'b0;
      rd_qaddr_reg <= {WORD_A{1'b0}};
    end else if (kp_rise && !s_rps_n) begin
      rd_queued_reg <= 1'b1;
      rd_qaddr_reg <= s_addr[WORD_A-1:0];
    end else if (rd_queued_reg && launch_p && burst_open(rd_state_reg)) begin
      rd_queued_reg <= 1'b0;
    end
  end
  // -----------------------------------------------
  // read state decode
  // -----------------------------------------------
  // the hold state is spare and behaves like idle
  always @* begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      `SSRM_RD_IDLE,
      `SSRM_RD_HOLD: begin
        if (launch_p && rd_queued_reg) begin
          rd_state_next = `SSRM_RD_W0;
        end else if (launch_p) begin
          rd_state_next = `SSRM_RD_IDLE;
        end
      end
      `SSRM_RD_W0: begin
        if (launch_n) begin
          rd_state_next = `SSRM_RD_W1;
        end
      end
      `SSRM_RD_W1: begin
        if (launch_p && rd_queued_reg) begin
          rd_state_next = `SSRM_RD_W0;
        end else if (launch_p) begin
          rd_state_next = `SSRM_RD_IDLE;
        end
      end
      default: begin
        rd_state_next = `SSRM_RD_IDLE;
      end
    endcase
  end
  // -----------------------------------------------
  // read state register
  // -----------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      rd_state_reg <= `SSRM_RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end
  // -----------------------------------------------
  // read data and output enable registers
  // -----------------------------------------------
  // outputs come from flops so the pins never glitch between words
  always @(posedge clock) begin
    if (srst) begin
      rd_addr_reg <= {WORD_A{1'b0}};
      rdata <= {DATA_W{1'b0}};
      rdata_oe_n <= 1'b1;
    end else begin
      if (rd_state_next == `SSRM_RD_W0 && rd_state_reg != `SSRM_RD_W0) begin
        rd_addr_reg <= rd_qaddr_reg;
        rdata <= bank0[rd_qaddr_reg];
        rdata_oe_n <= 1'b0;
      end else if (rd_state_next == `SSRM_RD_W1 && rd_state_reg == `SSRM_RD_W0) begin
        rdata <= bank1[rd_addr_reg];
      end else if (rd_state_next == `SSRM_RD_IDLE) begin
        rdata_oe_n <= 1'b1;
      end
    end
  end
  // -----------------------------------------------
  // echo clocks
  // -----------------------------------------------
  // follow the chosen clock pair level, three clock cycles late
  // level copies only: the phase is no finer than one clock period
  wire echo_src_p = s_single ? kp_lvl : cp_lvl;
  wire echo_src_n = s_single ? kn_lvl : cn_lvl;
  always @(posedge clock) begin
    if (srst) begin
      echo_strobe <= 1'b0;
      echo_strobe_n <= 1'b1;
    end else begin
      echo_strobe <= echo_src_p;
      echo_strobe_n <= echo_src_n;
    end
  end
endmodule
`default_nettype wire

// [tb/ssrm_chk_sva.sv]
// pin checker for the separate-port sram
// assumes pin clocks of eight system clocks per period
`timescale 1ns/1ns
`default_nettype none
module ssrm_chk #(
  parameter DATA_W = 18,
  parameter ADDR_W = 19,
  parameter LANES = 2
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_clk_p,
  input wire logic in_clk_n,
  input wire logic out_clk_p,
  input wire logic out_clk_n,
  input wire logic single_clock_mode,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [LANES-1:0] lane_write_strobe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic rdata_oe_n,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n
);
  logic [5:0] idle_reg, lp_reg, ln_reg;
  logic lp_d_reg, ln_d_reg;
  wire lp = single_clock_mode ? in_clk_p : out_clk_p;
  wire ln = single_clock_mode ? in_clk_n : out_clk_n;
  // saturating ages; coarse bounds since latency is not exact
  always @(posedge clock) begin
    lp_d_reg <= lp;
    ln_d_reg <= ln;
    idle_reg <= (srst || !read_port_select_n) ? 6'h0 : idle_reg + {5'h0, idle_reg != 6'h3f};
    lp_reg <= srst ? 6'h3f : (lp && !lp_d_reg) ? 6'h0 : lp_reg + {5'h0, lp_reg != 6'h3f};
    ln_reg <= srst ? 6'h3f : (ln && !ln_d_reg) ? 6'h0 : ln_reg + {5'h0, ln_reg != 6'h3f};
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_read_taken; $rose(in_clk_p) && !read_port_select_n; endsequence
  sequence s_norm_edge; (!single_clock_mode)[*8] ##0 $rose(out_clk_p); endsequence
  sequence s_single_edge; single_clock_mode[*8] ##0 $rose(in_clk_p); endsequence
  sequence s_norm_n_edge; (!single_clock_mode)[*8] ##0 $rose(out_clk_n); endsequence
  property p_echo_n; s_norm_n_edge |-> ##[1:4] echo_strobe_n; endproperty
  property p_read_answer; s_read_taken |-> ##[4:24] !rdata_oe_n; endproperty
  property p_float; idle_reg > 6'd24 |-> rdata_oe_n; endproperty
  property p_burst; $fell(rdata_oe_n) |=> !rdata_oe_n[*6]; endproperty
  property p_word_hold; !rdata_oe_n && $changed(rdata) |=> $stable(rdata)[*3]; endproperty
  property p_launch; !rdata_oe_n && $changed(rdata) |-> lp_reg < 6'd7 || ln_reg < 6'd7;
  endproperty
  property p_echo_norm; s_norm_edge |-> ##[1:4] echo_strobe; endproperty
  property p_echo_single; s_single_edge |-> ##[1:4] echo_strobe; endproperty
  property p_reset; disable iff (1'b0) srst |=> rdata_oe_n && !echo_strobe && echo_strobe_n;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_float: assert property (p_float) else $error("outputs still driven");
  a_burst: assert property (p_burst) else $error("burst too short");
  a_word_hold: assert property (p_word_hold) else $error("word changed early");
  a_launch: assert property (p_launch) else $error("word off launch edge");
  a_echo_norm: assert property (p_echo_norm) else $error("echo lost output clock");
  a_echo_single: assert property (p_echo_single) else $error("echo lost input clock");
  a_reset: assert property (p_reset) else $error("reset levels wrong");
  a_echo_n: assert property (p_echo_n) else $error("echo pair lost output clock");
endmodule
bind ssrm_core ssrm_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_chk (
  .clock(clock), .srst(srst), .in_clk_p(in_clk_p), .in_clk_n(in_clk_n),
  .out_clk_p(out_clk_p), .out_clk_n(out_clk_n), .single_clock_mode(single_clock_mode),
  .read_port_select_n(read_port_select_n), .write_port_select_n(write_port_select_n),
  .lane_write_strobe_n(lane_write_strobe_n), .addr(addr), .wdata(wdata), .rdata(rdata),
  .rdata_oe_n(rdata_oe_n), .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n));
`default_nettype wire

// [tb/ssrm_ctrl_model.sv]
// memory controller model driving the sram pins
// assumes 8 system clocks per pin clock period
`timescale 1ns/1ns
`default_nettype none
module ssrm_ctrl_model (
  input wire logic clock,
  input wire logic srst,
  output var logic in_clk_p,
  output var logic in_clk_n,
  output var logic out_clk_p,
  output var logic out_clk_n,
  output var logic read_port_select_n,
  output var logic write_port_select_n,
  output var logic [1:0] lane_write_strobe_n,
  output var logic [18:0] addr,
  output var logic [17:0] wdata
);
  logic [2:0] ph_reg;
  wire [2:0] oph = ph_reg + 3'h3;
  always @(posedge clock) ph_reg <= srst ? 3'h0 : ph_reg + 3'h1;
  // output pair lags by five so a launch always follows its take
  always_comb begin
    in_clk_p = !ph_reg[2];
    in_clk_n = ph_reg[2];
    out_clk_p = !oph[2];
    out_clk_n = oph[2];
  end
  initial begin
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    lane_write_strobe_n = 2'h3;
    addr = 19'h0;
    wdata = 18'h0;
  end
  // pins change two clocks clear of each input clock edge
  task op(input logic rd, input logic [18:0] ra, input logic wr, input logic [18:0] wa,
      input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] b0, input logic [1:0] b1);
    @(posedge clock);
    while (ph_reg != 3'h5) @(posedge clock);
    read_port_select_n <= !rd;
    write_port_select_n <= !wr;
    addr <= ra;
    wdata <= d0;
    lane_write_strobe_n <= b0;
    @(posedge clock);
    while (ph_reg != 3'h1) @(posedge clock);
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    addr <= wa;
    wdata <= d1;
    lane_write_strobe_n <= b1;
    @(posedge clock);
    while (ph_reg != 3'h5) @(posedge clock);
    addr <= ~wa;
    wdata <= ~d1;
    lane_write_strobe_n <= ~b1;
  endtask
endmodule
`default_nettype wire

// [tb/ssrm_core_bench.sv]
// self-checking bench for the separate-port sram
// assumes the controller model owns every pin but mode and reset
`timescale 1ns/1ns
`default_nettype none
module ssrm_core_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic single_clock_mode = 1'b0;
  wire kp, kn, cp, cn, rps_n, wps_n, oe_n, eq, eq_n;
  wire [1:0] bw_n;
  wire [18:0] addr;
  wire [17:0] wdata, rdata;
  integer n_fail = 0;
  integer n_tests = 0;
  always #25 clock = ~clock;
  ssrm_ctrl_model ctl (.clock(clock), .srst(srst), .in_clk_p(kp), .in_clk_n(kn),
    .out_clk_p(cp), .out_clk_n(cn), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .lane_write_strobe_n(bw_n), .addr(addr), .wdata(wdata));
  ssrm_core dut (.clock(clock), .srst(srst), .in_clk_p(kp), .in_clk_n(kn), .out_clk_p(cp),
    .out_clk_n(cn), .single_clock_mode(single_clock_mode), .read_port_select_n(rps_n),
    .write_port_select_n(wps_n), .lane_write_strobe_n(bw_n), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rdata_oe_n(oe_n), .echo_strobe(eq), .echo_strobe_n(eq_n));
  task check(input logic [17:0] got, input logic [17:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read, optionally with a write in the same cycle, then judge the burst
  task rd_check(input logic [18:0] a, input logic wr, input logic [18:0] wa,
      input logic [17:0] e0, input logic [17:0] e1);
    integer i;
    ctl.op(1'b1, a, wr, wa, 18'h00111, 18'h00222, 2'h0, 2'h0);
    i = 0;
    while (oe_n !== 1'b0 && i < 40) begin
      @(negedge clock);
      i = i + 1;
    end
    check({17'h0, oe_n}, 18'h0);
    repeat (2) @(negedge clock);
    check(rdata, e0);
    repeat (4) @(negedge clock);
    check(rdata, e1);
    repeat (6) @(negedge clock);
    check({17'h0, oe_n}, 18'h1);
  endtask
  task t_full;
    ctl.op(1'b0, 19'h0, 1'b1, 19'h5, 18'h12345, 18'h0abcd, 2'h0, 2'h0);
    rd_check(19'h5, 1'b0, 19'h0, 18'h12345, 18'h0abcd);
  endtask
  task t_lanes;
    ctl.op(1'b0, 19'h0, 1'b1, 19'h5, 18'h3ffff, 18'h3ffff, 2'h2, 2'h1);
    rd_check(19'h5, 1'b0, 19'h0, 18'h123ff, 18'h3ffcd);
  endtask
  task t_both_ports;
    rd_check(19'h5, 1'b1, 19'h9, 18'h123ff, 18'h3ffcd);
    ctl.op(1'b0, 19'h9, 1'b0, 19'h9, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
    rd_check(19'h9, 1'b0, 19'h0, 18'h00111, 18'h00222);
  endtask
  // mode pin is synchronised, so let it settle before a read
  task t_single;
    @(posedge clock);
    single_clock_mode <= 1'b1;
    repeat (16) @(posedge clock);
    rd_check(19'h5, 1'b0, 19'h0, 18'h123ff, 18'h3ffcd);
    @(posedge clock);
    single_clock_mode <= 1'b0;
    repeat (16) @(posedge clock);
  endtask
  task stop_test;
    $display("mismatches %0d of %0d checks", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #250000;
    n_fail = n_fail + 1;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    repeat (16) @(posedge clock);
    t_full;
    t_lanes;
    t_both_ports;
    t_single;
    t_full;
    stop_test;
  end
endmodule
`default_nettype wire
